// ==== design/spi_stat_dev.sv ====
// Purpose: device end; decodes commands, reports status and read data
// Assumes: mode 0 link, sclk from the master, internal 32-bit access port
// Notes:   link logic runs on sclk; toggles carry requests across domains
`timescale 1ns/1ps

// What this block does
// - status never launches an internal access
// - master lowers select before any clock
// - one bit each way per clock
// - opcode in bits 2-3, echo previous
// - bit 8 carries completion flag in status frames; bit 40 in read, bit 72 in write
// - master repolls while flag is zero
// - finished read returns word MSB first
// - finished write has no bits after its flag at bit 72
// - unfinished read or poll trails 32 dummy bits
// - status frame is 40 clocks
// - data only when previous op read
// - select returns high between commands
// - write code 01 remembered as previous
// - read code 10 reported with word
// - internal accesses always full word
module spi_stat_dev
  import spi_stat_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  spi_link_if.dev          link,
  output logic             acc_valid,
  output logic             acc_write,
  output logic [23:0]      acc_addr,
  output logic [31:0]      acc_wdata,
  input  wire logic        acc_ack,
  input  wire logic [31:0] acc_rdata
);
  typedef enum logic [0:0] {
    S_IDLE = 1'b0,
    S_BUSY = 1'b1
  } acc_state_t;

  // frame state, cleared whenever select is high
  logic        frame_rst;
  bit_cnt_t    cnt_r;
  bit_cnt_t    cnt_nxt;
  logic [31:0] sh_r;
  logic [31:0] sh_nxt;
  logic [1:0]  op_r;
  logic [1:0]  op_nxt;
  logic [3:0]  be_r;
  logic [3:0]  be_nxt;
  logic [23:0] addr_r;
  logic [23:0] addr_nxt;

  // held access record on the link side
  logic [1:0]  prev_op_r;
  logic [1:0]  prev_op_nxt;
  logic [3:0]  prev_be_r;
  logic [3:0]  prev_be_nxt;
  logic [23:0] prev_addr_r;
  logic [23:0] prev_addr_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic        req_tgl_r;
  logic        req_tgl_nxt;
  logic        ack_s1_r;
  logic        ack_s2_r;
  logic        done;

  // output side, falling sclk
  logic        miso_r;
  logic        miso_nxt;
  logic        done_lat_r;
  logic        done_lat_nxt;
  bit_cnt_t    k;
  bit_cnt_t    stat_pos;
  bit_cnt_t    idx;

  // system side
  acc_state_t  st_r;
  acc_state_t  st_nxt;
  logic        req_s1_r;
  logic        req_s2_r;
  logic        req_seen_r;
  logic        req_seen_nxt;
  logic        ack_tgl_r;
  logic        ack_tgl_nxt;
  logic        valid_r;
  logic        valid_nxt;
  logic        write_r;
  logic        write_nxt;
  logic [23:0] a_addr_r;
  logic [23:0] a_addr_nxt;
  logic [31:0] a_wdata_r;
  logic [31:0] a_wdata_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // select high ends the frame even though sclk has stopped
  assign frame_rst = ~rst_n | link.sel_n;

  always_comb begin
    cnt_nxt  = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 7'h01;
    sh_nxt   = {sh_r[30:0], link.mosi};
    op_nxt   = op_r;
    be_nxt   = be_r;
    addr_nxt = addr_r;
    if (cnt_nxt == OP_LAST) begin
      op_nxt = sh_nxt[1:0];
    end
    if (cnt_nxt == BE_LAST) begin
      be_nxt = sh_nxt[3:0];
    end
    if (cnt_nxt == ADDR_LAST) begin
      addr_nxt = sh_nxt[23:0];
    end
  end

  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_r  <= 7'h00;
      sh_r   <= 32'h0;
      op_r   <= OP_STATUS;
      be_r   <= 4'h0;
      addr_r <= 24'h0;
    end else begin
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      op_r   <= op_nxt;
      be_r   <= be_nxt;
      addr_r <= addr_nxt;
    end
  end

  // commit only from read or write; a status frame leaves all of it alone
  always_comb begin
    prev_op_nxt   = prev_op_r;
    prev_be_nxt   = prev_be_r;
    prev_addr_nxt = prev_addr_r;
    wdata_nxt     = wdata_r;
    req_tgl_nxt   = req_tgl_r;
    if (cnt_nxt == ADDR_LAST && op_r == OP_READ) begin
      prev_op_nxt   = OP_READ;
      prev_be_nxt   = be_r;
      prev_addr_nxt = sh_nxt[23:0];
      req_tgl_nxt   = ~req_tgl_r;
    end
    if (cnt_nxt == DATA_LAST && op_r == OP_WRITE) begin
      prev_op_nxt   = OP_WRITE;
      prev_be_nxt   = be_r;
      prev_addr_nxt = addr_r;
      wdata_nxt     = sh_nxt;
      req_tgl_nxt   = ~req_tgl_r;
    end
  end

  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_op_r   <= PREV_OP_RST;
      prev_be_r   <= 4'h0;
      prev_addr_r <= 24'h0;
      wdata_r     <= 32'h0;
      req_tgl_r   <= 1'b0;
      ack_s1_r    <= 1'b0;
      ack_s2_r    <= 1'b0;
    end else begin
      prev_op_r   <= prev_op_nxt;
      prev_be_r   <= prev_be_nxt;
      prev_addr_r <= prev_addr_nxt;
      wdata_r     <= wdata_nxt;
      req_tgl_r   <= req_tgl_nxt;
      ack_s1_r    <= ack_tgl_r;
      ack_s2_r    <= ack_s1_r;
    end
  end

  // the ack sync only advances while the master clocks a frame
  assign done = (ack_s2_r == req_tgl_r);

  always_comb begin
    k            = cnt_r + 7'h01;
    miso_nxt     = 1'b0;
    done_lat_nxt = done_lat_r;
    idx          = 7'h00;
    unique case (op_r)
      OP_READ:  stat_pos = STAT_READ;
      OP_WRITE: stat_pos = STAT_WRITE;
      default:  stat_pos = STAT_STATUS;
    endcase
    if (k == 7'h02) begin
      miso_nxt = prev_op_r[1];
    end
    if (k == OP_LAST) begin
      miso_nxt = prev_op_r[0];
    end
    if (op_r != OP_STATUS && k >= BE_FIRST && k <= BE_LAST) begin
      idx      = BE_LAST - k;
      miso_nxt = prev_be_r[idx[1:0]];
    end
    if (op_r != OP_STATUS && k >= ADDR_FIRST && k <= ADDR_LAST) begin
      idx      = ADDR_LAST - k;
      miso_nxt = prev_addr_r[idx[4:0]];
    end
    if (k == stat_pos) begin
      miso_nxt     = done;
      done_lat_nxt = done;
    end
    // rdata is quiet once done is seen, so reading it here is safe
    if (op_r != OP_WRITE && done_lat_r && prev_op_r == OP_READ
        && k > stat_pos && k <= stat_pos + WORD_BITS) begin
      idx      = stat_pos + WORD_BITS - k;
      miso_nxt = rdata_r[idx[4:0]];
    end
  end

  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      miso_r     <= 1'b0;
      done_lat_r <= 1'b0;
    end else begin
      miso_r     <= miso_nxt;
      done_lat_r <= done_lat_nxt;
    end
  end

  assign link.miso = miso_r;

  always_comb begin
    st_nxt       = st_r;
    req_seen_nxt = req_seen_r;
    ack_tgl_nxt  = ack_tgl_r;
    valid_nxt    = valid_r;
    write_nxt    = write_r;
    a_addr_nxt   = a_addr_r;
    a_wdata_nxt  = a_wdata_r;
    rdata_nxt    = rdata_r;
    unique case (st_r)
      S_IDLE: begin
        if (req_s2_r != req_seen_r) begin
          req_seen_nxt = req_s2_r;
          valid_nxt    = 1'b1;
          write_nxt    = (prev_op_r == OP_WRITE);
          a_addr_nxt   = prev_addr_r;
          a_wdata_nxt  = wdata_r;
          st_nxt       = S_BUSY;
        end
      end
      S_BUSY: begin
        if (acc_ack) begin
          valid_nxt   = 1'b0;
          ack_tgl_nxt = req_seen_r;
          if (!write_r) begin
            rdata_nxt = acc_rdata;
          end
          st_nxt = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= S_IDLE;
      req_s1_r   <= 1'b0;
      req_s2_r   <= 1'b0;
      req_seen_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
      valid_r    <= 1'b0;
      write_r    <= 1'b0;
      a_addr_r   <= 24'h0;
      a_wdata_r  <= 32'h0;
      rdata_r    <= 32'h0;
    end else begin
      st_r       <= st_nxt;
      req_s1_r   <= req_tgl_r;
      req_s2_r   <= req_s1_r;
      req_seen_r <= req_seen_nxt;
      ack_tgl_r  <= ack_tgl_nxt;
      valid_r    <= valid_nxt;
      write_r    <= write_nxt;
      a_addr_r   <= a_addr_nxt;
      a_wdata_r  <= a_wdata_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign acc_valid = valid_r;
  assign acc_write = write_r;
  assign acc_addr  = a_addr_r;
  assign acc_wdata = a_wdata_r;
endmodule : spi_stat_dev

// ==== design/spi_stat_host.sv ====
// Purpose: master end; runs frames and polls status until done
// Assumes: sclk derived from clk_sys by a divider, mode 0
// Notes:   one command at a time; response only once finished
`timescale 1ns/1ps
module spi_stat_host
  import spi_stat_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  spi_link_if.mst          link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_op,
  input  wire logic [23:0] cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  output logic             rsp_valid,
  output logic [1:0]       rsp_prev_op,
  output logic [31:0]      rsp_rdata
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_SETUP = 3'h1,
    H_SHIFT = 3'h2,
    H_END   = 3'h3,
    H_GAP   = 3'h4
  } host_state_t;

  host_state_t st_r, st_nxt;
  logic [2:0]  div_r, div_nxt;
  logic        tick;
  logic        sclk_r, sclk_nxt;
  logic        sel_n_r, sel_n_nxt;
  logic        mosi_r, mosi_nxt;
  logic [71:0] tx_r, tx_nxt;
  logic [71:0] rx_r, rx_nxt;
  bit_cnt_t    bits_r, bits_nxt;
  logic [1:0]  op_r, op_nxt;
  bit_cnt_t    len_r, len_nxt;
  logic        poll_r, poll_nxt;
  logic        ready_r, ready_nxt;
  logic        rv_r, rv_nxt;
  logic [1:0]  rop_r, rop_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        miso_s1_r, miso_s2_r;
  logic        done_bit;
  logic [1:0]  echo_op;

  function automatic logic [71:0] frame_of(input logic [1:0]  op,
                                           input logic [23:0] addr,
                                           input logic [31:0] wd);
    logic [71:0] f;
    f = 72'h0;
    unique case (op)
      OP_WRITE: f = {1'b0, op, BE_WRITE, 1'b0, addr, wd, 8'h00};
      OP_READ:  f = {1'b0, op, BE_READ, 1'b0, addr, 32'h0, 8'h00};
      default:  f = {1'b0, OP_STATUS, 69'h0};
    endcase
    return f;
  endfunction : frame_of

  assign tick     = (div_r == SCLK_HALF - 3'h1);
  // write status sits in the last bit; read and status at bit 32 from end
  assign done_bit = (op_r == OP_WRITE) ? rx_r[0] : rx_r[32];
  assign echo_op  = (op_r == OP_STATUS) ? rx_r[38:37] : rx_r[70:69];

  always_comb begin
    st_nxt    = st_r;
    div_nxt   = (st_r == H_IDLE || tick) ? 3'h0 : div_r + 3'h1;
    sclk_nxt  = sclk_r;
    sel_n_nxt = sel_n_r;
    mosi_nxt  = mosi_r;
    tx_nxt    = tx_r;
    rx_nxt    = rx_r;
    bits_nxt  = bits_r;
    op_nxt    = op_r;
    len_nxt   = len_r;
    poll_nxt  = poll_r;
    ready_nxt = ready_r;
    rv_nxt    = 1'b0;
    rop_nxt   = rop_r;
    rd_nxt    = rd_r;
    unique case (st_r)
      H_IDLE: begin
        if (cmd_valid && ready_r) begin
          tx_nxt    = frame_of(cmd_op, cmd_addr, cmd_wdata);
          mosi_nxt  = 1'b0;
          op_nxt    = cmd_op;
          len_nxt   = (cmd_op == OP_STATUS) ? LEN_STATUS : LEN_RW;
          sel_n_nxt = 1'b0;
          ready_nxt = 1'b0;
          bits_nxt  = 7'h00;
          st_nxt    = H_SETUP;
        end
      end
      H_SETUP: begin
        if (tick) begin
          st_nxt = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (tick && !sclk_r) begin
          sclk_nxt = 1'b1;
          rx_nxt   = {rx_r[70:0], miso_s2_r};
          bits_nxt = bits_r + 7'h01;
        end else if (tick) begin
          sclk_nxt = 1'b0;
          if (bits_r == len_r) begin
            st_nxt = H_END;
          end else begin
            tx_nxt   = {tx_r[70:0], 1'b0};
            mosi_nxt = tx_r[70];
          end
        end
      end
      H_END: begin
        if (tick) begin
          sel_n_nxt = 1'b1;
          poll_nxt  = ~done_bit;
          rop_nxt   = echo_op;
          rd_nxt    = rx_r[31:0];
          rv_nxt    = done_bit;
          st_nxt    = H_GAP;
        end
      end
      H_GAP: begin
        if (tick && poll_r) begin
          tx_nxt    = frame_of(OP_STATUS, 24'h0, 32'h0);
          mosi_nxt  = 1'b0;
          op_nxt    = OP_STATUS;
          len_nxt   = LEN_STATUS;
          sel_n_nxt = 1'b0;
          bits_nxt  = 7'h00;
          st_nxt    = H_SETUP;
        end else if (tick) begin
          ready_nxt = 1'b1;
          st_nxt    = H_IDLE;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= H_IDLE;
      div_r     <= 3'h0;
      sclk_r    <= 1'b0;
      sel_n_r   <= 1'b1;
      mosi_r    <= 1'b0;
      tx_r      <= 72'h0;
      rx_r      <= 72'h0;
      bits_r    <= 7'h00;
      op_r      <= OP_STATUS;
      len_r     <= LEN_STATUS;
      poll_r    <= 1'b0;
      ready_r   <= 1'b0;
      rv_r      <= 1'b0;
      rop_r     <= PREV_OP_RST;
      rd_r      <= 32'h0;
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      div_r     <= div_nxt;
      sclk_r    <= sclk_nxt;
      sel_n_r   <= sel_n_nxt;
      mosi_r    <= mosi_nxt;
      tx_r      <= tx_nxt;
      rx_r      <= rx_nxt;
      bits_r    <= bits_nxt;
      op_r      <= op_nxt;
      len_r     <= len_nxt;
      poll_r    <= poll_nxt;
      ready_r   <= (st_r == H_IDLE && !(cmd_valid && ready_r)) | ready_nxt;
      rv_r      <= rv_nxt;
      rop_r     <= rop_nxt;
      rd_r      <= rd_nxt;
      miso_s1_r <= link.miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  assign link.sclk   = sclk_r;
  assign link.sel_n  = sel_n_r;
  assign link.mosi   = mosi_r;
  assign cmd_ready   = ready_r;
  assign rsp_valid   = rv_r;
  assign rsp_prev_op = rop_r;
  assign rsp_rdata   = rd_r;
endmodule : spi_stat_host

// ==== dv/spi_stat_monitor.sv ====
// Purpose: wire checks on the link between the two ends
// Assumes: sclk comes from clk_sys, so it is sampled on clk_sys
// Notes:   frame fields are collected in helper flops
`timescale 1ns/1ps
module spi_stat_monitor
  import spi_stat_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic miso
);
  bit_cnt_t   cnt_r;
  logic [1:0] mop_r;
  logic [1:0] sop_r;
  logic [1:0] prev_r;
  logic       stb_r;
  logic       dor_r;
  logic       done_r;
  bit_cnt_t   idx;

  assign idx = cnt_r + 7'h01;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 7'h00;
      mop_r  <= 2'h0;
      sop_r  <= 2'h0;
      prev_r <= PREV_OP_RST;
      stb_r  <= 1'b0;
      dor_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      // frame end: only full read/write frames replace the echoed op
      if ($rose(sel_n)) begin
        if (cnt_r == LEN_RW) begin
          prev_r <= mop_r;
          done_r <= 1'b0;
        end else begin
          done_r <= stb_r;
        end
      end
      if (sel_n) begin
        cnt_r <= 7'h00;
        dor_r <= 1'b0;
      end else if ($rose(sclk)) begin
        cnt_r <= idx;
        if (idx == 7'h02 || idx == OP_LAST) begin
          mop_r <= {mop_r[0], mosi};
          sop_r <= {sop_r[0], miso};
        end
        if (idx == STAT_STATUS) stb_r <= miso;
        if (idx >= ADDR_FIRST && idx <= STAT_READ) dor_r <= dor_r | miso;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_idle_gap;
    sel_n [*4];
  endsequence
  sequence s_frame_end;
    $rose(sel_n);
  endsequence

  AST_SEL_BEFORE_CLK: assert property ($rose(sclk) |-> !sel_n && $past(!sel_n))
    else $error("sclk rose without select held low");
  AST_SEL_GAP: assert property (s_frame_end |-> s_idle_gap)
    else $error("select high gap too short");
  AST_FRAME_LEN: assert property (s_frame_end |->
    cnt_r == LEN_STATUS || cnt_r == LEN_RW)
    else $error("frame bit count wrong");
  AST_OPCODE: assert property (s_frame_end |->
    (cnt_r == LEN_STATUS) == (mop_r == OP_STATUS))
    else $error("opcode does not match frame length");
  AST_ECHO_OP: assert property (s_frame_end |-> sop_r == prev_r)
    else $error("echoed opcode is not the previous access");
  AST_MOSI_STABLE: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  AST_MISO_FALL: assert property (!sel_n && $past(!sel_n) && $changed(miso)
    |-> $fell(sclk))
    else $error("miso moved away from sclk fall");
  AST_DATA_ZERO: assert property ((s_frame_end and (cnt_r == LEN_STATUS &&
    !(stb_r && prev_r == OP_READ))) |-> !dor_r)
    else $error("status frame carried data without finished read");
  AST_DONE_STICKY: assert property ((s_frame_end and (cnt_r == LEN_STATUS &&
    done_r)) |-> stb_r)
    else $error("completion flag dropped on a later poll");

  cover property (s_frame_end and (cnt_r == LEN_STATUS && stb_r &&
    prev_r == OP_READ));
endmodule : spi_stat_monitor

// ==== dv/testbench.sv ====
// Purpose: drives both link ends through their user sides
// Assumes: host makes sclk; bench answers the device access port
// Notes:   long ack delays force status repolls
`timescale 1ns/1ps
module testbench;
  import spi_stat_pkg::*;
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b1; // high first, so the drop is a real edge
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_op    = 2'h0;
  logic [23:0] cmd_addr  = 24'h000000;
  logic [31:0] cmd_wdata = 32'h00000000;
  logic        acc_ack   = 1'b0;
  logic [31:0] acc_rdata = 32'h00000000;
  logic [31:0] seed      = 32'had01c427;
  logic [31:0] last_rd   = 32'h00000000;
  logic [1:0]  prev_m    = PREV_OP_RST;
  logic [31:0] rword     = 32'h00000000;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [1:0]  rsp_prev_op;
  logic [31:0] rsp_rdata;
  logic        acc_valid;
  logic        acc_write;
  logic [23:0] acc_addr;
  logic [31:0] acc_wdata;
  int          err_total    = 0;
  int          total_checks = 0;
  int          frames       = 0;
  int          bits         = 0;
  int          naccs        = 0;
  int          dly          = 0;

  spi_link_if link ();
  spi_stat_dev spi_stat_dev_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
    .acc_rdata(acc_rdata));
  spi_stat_host spi_stat_host_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_prev_op(rsp_prev_op),
    .rsp_rdata(rsp_rdata));
  spi_stat_monitor spi_stat_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .sclk(link.sclk), .sel_n(link.sel_n), .mosi(link.mosi),
    .miso(link.miso));

  initial forever #12.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // bench's own count of frames and bits on the wire
  always @(negedge link.sel_n) frames++;
  always @(posedge link.sclk) bits++;
  always @(posedge link.sel_n) begin
    if (rst_n) begin
      chk(bits, (frames == 1 && cmd_op != OP_STATUS) ? 72 : 40);
      bits = 0;
    end
  end

  // access port answered after dly cycles, data random
  always @(negedge clk_sys) begin
    acc_ack <= 1'b0;
    if (acc_valid && !acc_ack) begin
      if (dly == 0) begin
        acc_ack   <= 1'b1;
        acc_rdata <= rword;
      end else begin
        dly--;
      end
    end
  end
  always @(posedge clk_sys) begin
    if (acc_valid && acc_ack) begin
      naccs++;
      chk(acc_write, cmd_op == OP_WRITE);
      chk(acc_addr, cmd_addr);
      if (cmd_op == OP_WRITE) chk(acc_wdata, cmd_wdata);
    end
  end

  task automatic run(input logic [1:0] op, input int d);
    logic [31:0] t;
    int          n;
    t = xs();
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    frames = 0;
    bits = 0;
    naccs = 0;
    dly = d;
    rword = xs();
    cmd_addr = t[23:0];
    cmd_wdata = xs();
    cmd_op = op;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(rsp_valid, 1'b1);
    chk(rsp_prev_op, (op == OP_STATUS || frames == 1) ? prev_m : op);
    if (op == OP_READ) chk(rsp_rdata, rword);
    if (op == OP_STATUS)
      chk(rsp_rdata, prev_m == OP_READ ? last_rd : 32'h0);
    chk(naccs, op != OP_STATUS);
    if (op != OP_STATUS) chk(frames > 1, d > 200);
    if (op != OP_STATUS) prev_m = op;
    if (op == OP_READ) last_rd = rword;
  endtask : run

  initial begin
    logic [31:0] r;
    #5;
    rst_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    // polls follow a write, a read and another poll
    for (int i = 0; i < 15; i++) begin
      r = xs();
      run(i % 5 == 0 ? OP_WRITE : (i % 5 == 2 ? OP_READ : OP_STATUS),
          (i % 5 == 2 || i == 0) ? 300 + int'(r[8:0]) : int'(r[1:0]));
    end
    close_out();
  end

  // budget: 15 commands of a few thousand cycles each
  initial begin
    #(25 * 90000);
    err_total++;
    close_out();
  end
endmodule : testbench

// ==== inc/spi_link_if.sv ====
// Purpose: four-wire serial link between master and device ends
// Assumes: master makes sclk; sel_n frames every command
// Notes:   no clocking block; the bench joins both ends here
`timescale 1ns/1ps
interface spi_link_if;
  logic sclk;
  logic sel_n;
  logic mosi;
  logic miso;

  modport dev (
    input  sclk,
    input  sel_n,
    input  mosi,
    output miso
  );

  modport mst (
    output sclk,
    output sel_n,
    output mosi,
    input  miso
  );
endinterface : spi_link_if

// ==== inc/spi_stat_pkg.sv ====
// Purpose: shared constants for the serial host port status/read/write link
// Assumes: mode 0 framing, 40-bit status and 72-bit read/write frames
// Notes:   bit numbers count from 1 as the link does
package spi_stat_pkg;
  typedef logic [6:0] bit_cnt_t;

  localparam logic [1:0] OP_STATUS = 2'h0;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] PREV_OP_RST = 2'h0;

  localparam bit_cnt_t LEN_STATUS  = 7'h28;
  localparam bit_cnt_t LEN_RW      = 7'h48;
  localparam bit_cnt_t OP_LAST     = 7'h03;
  localparam bit_cnt_t BE_FIRST    = 7'h04;
  localparam bit_cnt_t BE_LAST     = 7'h07;
  localparam bit_cnt_t ADDR_FIRST  = 7'h09;
  localparam bit_cnt_t ADDR_LAST   = 7'h20;
  localparam bit_cnt_t DATA_LAST   = 7'h40;
  localparam bit_cnt_t STAT_STATUS = 7'h08;
  localparam bit_cnt_t STAT_READ   = 7'h28;
  localparam bit_cnt_t STAT_WRITE  = 7'h48;
  localparam bit_cnt_t WORD_BITS   = 7'h20;
  localparam bit_cnt_t CNT_MAX     = 7'h7f;

  localparam logic [3:0] BE_READ   = 4'hf;
  localparam logic [3:0] BE_WRITE  = 4'h0;
  // half period of the generated serial clock, in clk_sys cycles
  localparam logic [2:0] SCLK_HALF = 3'h4;
endpackage : spi_stat_pkg
